// *** logic/pms_queue.sv ***
`timescale 1ns/1ps
package pms_pkg;
   localparam int          ADDR_W       = 24;
   localparam int          DATA_W       = 8;
   localparam int          QUEUE_DEPTH  = 3;          // instructions held ahead
   localparam logic [7:0]  MODE_REG_ADR = 8'h5e;      // processor mode register
   localparam int          MODE_LSB     = 0;          // mode bits 1 and 0
   localparam int          MODE_MSB     = 1;
   localparam logic [1:0]  MODE_SINGLE  = 2'h0;
   localparam logic [1:0]  MODE_EXPAND  = 2'h1;
   localparam logic [1:0]  MODE_MICRO   = 2'h2;
   localparam logic [1:0]  MODE_RESET   = MODE_SINGLE;
   localparam int          CLK_PERIOD_NS = 8;
   localparam int          WR_CYCLE_NS   = 16;       // length of an internal write cycle
   localparam int          WR_CYCLES     = (WR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [ADDR_W-1:0] ROM_BASE_RST  = 24'h00_8000;
   localparam logic [ADDR_W-1:0] ROM_LIMIT_RST = 24'h00_ffff;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic              ext;   // fetched from external bus
   } pms_entry_s;
endpackage : pms_pkg

// prefetch queue: flop storage indexed by read and write pointers
module pms_queue #(
   parameter int DEPTH = pms_pkg::QUEUE_DEPTH,
   parameter int CW    = $clog2(DEPTH + 1)
) (
   input  wire logic               clk_i,
   input  wire logic               rst_n_i,
   input  wire logic               flush_i,
   input  wire logic               push_i,
   input  wire pms_pkg::pms_entry_s push_ent_i,
   input  wire logic               pop_i,
   output pms_pkg::pms_entry_s     head_o,
   output logic                    valid_o,
   output logic [CW-1:0]           count_o
);
   import pms_pkg::*;
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   pms_entry_s    mem_q [DEPTH];
   logic [PW-1:0] rd_q;
   logic [PW-1:0] wr_q;
   logic [CW-1:0] cnt_q;
   logic          do_push;
   logic          do_pop;

   // a push into a full queue is dropped; the fetcher never issues one
   assign do_push = push_i && !flush_i && (cnt_q != CW'(DEPTH));
   assign do_pop  = pop_i && !flush_i && (cnt_q != '0);
   assign head_o  = mem_q[rd_q];
   assign valid_o = (cnt_q != '0);
   assign count_o = cnt_q;

   // one storage slot per entry
   for (genvar g = 0; g < DEPTH; g++)
   begin : g_slot
      always_ff @(posedge clk_i or negedge rst_n_i)
      begin
         if (!rst_n_i)
            mem_q[g] <= '0;
         else if (do_push && (wr_q == PW'(g)))
            mem_q[g] <= push_ent_i;
      end
   end

   // pointers and fill level; flush empties without touching storage
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rd_q  <= '0;
         wr_q  <= '0;
         cnt_q <= '0;
      end
      else if (flush_i)
      begin
         rd_q  <= '0;
         wr_q  <= '0;
         cnt_q <= '0;
      end
      else
      begin
         if (do_push)
            wr_q <= (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
         if (do_pop)
            rd_q <= (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
         cnt_q <= cnt_q + CW'(do_push) - CW'(do_pop);
      end
   end
endmodule : pms_queue

// *** logic/pms_mode_switch.sv ***
`timescale 1ns/1ps
module pms_mode_switch #(
   parameter int                          QDEPTH    = pms_pkg::QUEUE_DEPTH,
   parameter logic [pms_pkg::ADDR_W-1:0]  ROM_BASE  = pms_pkg::ROM_BASE_RST,
   parameter logic [pms_pkg::ADDR_W-1:0]  ROM_LIMIT = pms_pkg::ROM_LIMIT_RST,
   parameter logic [pms_pkg::ADDR_W-1:0]  START_PC  = pms_pkg::ROM_BASE_RST
) (
   input  wire logic                        sys_clk_i,
   input  wire logic                        arst_n_i,
   // register writes issued by the cpu
   input  wire logic                        reg_wr_i,
   input  wire logic [7:0]                  reg_addr_i,
   input  wire logic [pms_pkg::DATA_W-1:0]  reg_wdata_i,
   output logic                             reg_busy_o,
   // instruction hand-off to the execution unit
   output logic                             ins_valid_o,
   output pms_pkg::pms_entry_s              ins_o,
   input  wire logic                        ins_take_i,
   input  wire logic                        branch_i,
   input  wire logic [pms_pkg::ADDR_W-1:0]  branch_target_i,
   output logic [pms_pkg::ADDR_W-1:0]       pc_o,
   output logic [1:0]                       mode_o,
   // internal rom, data one cycle after enable
   output logic                             rom_en_o,
   output logic [pms_pkg::ADDR_W-1:0]       rom_addr_o,
   input  wire logic [pms_pkg::DATA_W-1:0]  rom_rdata_i,
   // external bus, four-phase request/acknowledge
   output logic                             ext_req_o,
   output logic [pms_pkg::ADDR_W-1:0]       ext_addr_o,
   input  wire logic                        ext_ack_i,
   input  wire logic [pms_pkg::DATA_W-1:0]  ext_rdata_i
);
   import pms_pkg::*;
   localparam int CW = $clog2(QDEPTH + 1);
   localparam int WCW = $clog2(WR_CYCLES + 1);

   typedef enum logic [1:0] {F_IDLE, F_ROM, F_EXT_REQ, F_EXT_REL} pms_fetch_e;

   logic              rst_m_q, rst_n_q;
   logic              ack_m_q, ack_q;
   logic [DATA_W-1:0] dat_m_q, dat_q;
   logic [1:0]        mode_q, mode_wr_q;
   logic [WCW-1:0]    wr_cnt_q;
   logic              wr_busy_q, wr_done;
   logic [ADDR_W-1:0] fa_q, pc_q;
   logic              drop_q;
   pms_fetch_e        st_q;
   logic              push;
   pms_entry_s        push_ent;
   logic [CW-1:0]     cnt;
   logic              micro, in_rom, issue;

   // reset release through two flops, assertion stays asynchronous
   always_ff @(posedge sys_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         rst_m_q <= 1'b0;
         rst_n_q <= 1'b0;
      end
      else
      begin
         rst_m_q <= 1'b1;
         rst_n_q <= rst_m_q;
      end
   end

   // external bus answers arrive off-clock; data is held while ack is high
   always_ff @(posedge sys_clk_i or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         ack_m_q <= 1'b0;
         ack_q   <= 1'b0;
         dat_m_q <= '0;
         dat_q   <= '0;
      end
      else
      begin
         ack_m_q <= ext_ack_i;
         ack_q   <= ack_m_q;
         dat_m_q <= ext_rdata_i;
         dat_q   <= dat_m_q;
      end
   end

   // write cycle to the mode register; the mode flips only at its end
   assign wr_done = wr_busy_q && (wr_cnt_q == WCW'(1));
   always_ff @(posedge sys_clk_i or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         wr_busy_q <= 1'b0;
         wr_cnt_q  <= '0;
         mode_wr_q <= MODE_RESET;
         mode_q    <= MODE_RESET;
      end
      else if (wr_busy_q)
      begin
         wr_cnt_q <= wr_cnt_q - 1'b1;
         if (wr_done)
         begin
            wr_busy_q <= 1'b0;
            mode_q    <= mode_wr_q;
         end
      end
      else if (reg_wr_i && (reg_addr_i == MODE_REG_ADR))
      begin
         wr_busy_q <= 1'b1;
         wr_cnt_q  <= WCW'(WR_CYCLES);
         mode_wr_q <= reg_wdata_i[MODE_MSB:MODE_LSB];
      end
   end

   // a rom read issued on the completing edge would run after the switch, so it is held off
   assign micro  = (mode_q == MODE_MICRO) || (wr_done && (mode_wr_q == MODE_MICRO));
   assign in_rom = (fa_q >= ROM_BASE) && (fa_q <= ROM_LIMIT);
   // one fetch in flight, so a free slot at issue is still free at push
   assign issue  = (st_q == F_IDLE) && !branch_i && (cnt < CW'(QDEPTH));

   // fetch engine; the source is chosen from the mode in force at issue
   always_ff @(posedge sys_clk_i or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         st_q       <= F_IDLE;
         fa_q       <= START_PC;
         rom_en_o   <= 1'b0;
         rom_addr_o <= '0;
         ext_req_o  <= 1'b0;
         ext_addr_o <= '0;
      end
      else
      begin
         rom_en_o <= 1'b0;
         case (st_q)
            F_IDLE:
            begin
               if (issue && in_rom && !micro)
               begin
                  rom_en_o   <= 1'b1;
                  rom_addr_o <= fa_q;
                  st_q       <= F_ROM;
               end
               else if (issue)
               begin
                  ext_req_o  <= 1'b1;
                  ext_addr_o <= fa_q;
                  st_q       <= F_EXT_REQ;
               end
            end
            F_ROM:
               st_q <= F_IDLE;
            F_EXT_REQ:
               if (ack_q)
               begin
                  ext_req_o <= 1'b0;
                  st_q      <= F_EXT_REL;
               end
            F_EXT_REL:
               if (!ack_q)
                  st_q <= F_IDLE;
            default:
               st_q <= F_IDLE;
         endcase
         if (branch_i)
            fa_q <= branch_target_i;
         else if (push)
            fa_q <= fa_q + 1'b1;
      end
   end

   // a branch during an open bus cycle discards its answer; the cycle still finishes
   // rom reads and acked cycles end in the branch cycle itself, so they need no drop
   always_ff @(posedge sys_clk_i or negedge rst_n_q)
   begin
      if (!rst_n_q)
         drop_q <= 1'b0;
      else if (branch_i && (st_q == F_EXT_REQ) && !ack_q)
         drop_q <= 1'b1;
      else if ((st_q == F_ROM) || ((st_q == F_EXT_REQ) && ack_q))
         drop_q <= 1'b0;
   end

   assign push = !drop_q && !branch_i
                 && ((st_q == F_ROM) || ((st_q == F_EXT_REQ) && ack_q));
   always_comb
   begin
      push_ent.addr = fa_q;
      push_ent.ext  = (st_q != F_ROM);
      push_ent.data = (st_q == F_ROM) ? rom_rdata_i : dat_q;
   end

   // queued entries keep their source; a mode change does not purge them
   pms_queue #(
      .DEPTH (QDEPTH),
      .CW    (CW)
   ) u_queue (
      .clk_i      (sys_clk_i),
      .rst_n_i    (rst_n_q),
      .flush_i    (branch_i),
      .push_i     (push),
      .push_ent_i (push_ent),
      .pop_i      (ins_take_i),
      .head_o     (ins_o),
      .valid_o    (ins_valid_o),
      .count_o    (cnt)
   );

   // program counter: address after the last instruction taken
   always_ff @(posedge sys_clk_i or negedge rst_n_q)
   begin
      if (!rst_n_q)
         pc_q <= START_PC;
      else if (branch_i)
         pc_q <= branch_target_i;
      else if (ins_take_i && ins_valid_o)
         pc_q <= ins_o.addr + 1'b1;
   end

   assign pc_o       = pc_q;
   assign mode_o     = mode_q;
   assign reg_busy_o = wr_busy_q;

   sequence s_mode_write;
      !wr_busy_q && reg_wr_i && (reg_addr_i == MODE_REG_ADR);
   endsequence

   sequence s_write_ends;
      wr_busy_q [*2] ##1 !wr_busy_q;
   endsequence

   a_mode_takes_bits: assert property (@(posedge sys_clk_i) disable iff (!rst_n_q)
      s_mode_write |=> s_write_ends ##0 (mode_q == $past(mode_wr_q)))
      else $error("mode did not take written bits");

   a_mode_only_done: assert property (@(posedge sys_clk_i) disable iff (!rst_n_q)
      !wr_done |=> $stable(mode_q))
      else $error("mode changed outside write completion");

   a_pc_follows: assert property (@(posedge sys_clk_i) disable iff (!rst_n_q)
      (ins_take_i && ins_valid_o && !branch_i) |=> (pc_o == $past(ins_o.addr) + 1'b1))
      else $error("pc not past taken instruction");

   a_rom_blocked: assert property (@(posedge sys_clk_i) disable iff (!rst_n_q)
      rom_en_o |-> (mode_q != MODE_MICRO))
      else $error("internal rom read in microprocessor mode");

   a_queue_bound: assert property (@(posedge sys_clk_i) disable iff (!rst_n_q)
      cnt <= CW'(QDEPTH))
      else $error("queue holds more than allowed");

   a_ext_route: assert property (@(posedge sys_clk_i) disable iff (!rst_n_q)
      $rose(ext_req_o) && ($past(mode_q) != MODE_MICRO) && (mode_q != MODE_MICRO) |->
         ((ext_addr_o < ROM_BASE) || (ext_addr_o > ROM_LIMIT)))
      else $error("rom-range fetch went external outside microprocessor mode");

   a_queued_kept: assert property (@(posedge sys_clk_i) disable iff (!rst_n_q)
      (ins_valid_o && !ins_take_i && !branch_i) |=> (ins_valid_o && $stable(ins_o)))
      else $error("queued instruction lost");

   a_branch_flush: assert property (@(posedge sys_clk_i) disable iff (!rst_n_q)
      branch_i |=> (!ins_valid_o && (fa_q == $past(branch_target_i))))
      else $error("branch did not flush queue");
endmodule : pms_mode_switch

// *** sim/pms_ext_mem.sv ***
`timescale 1ns/1ps
// external memory: answers a fetch after lat_i idle cycles, four-phase
module pms_ext_mem (
   input  wire logic        clk_i,
   input  wire logic        req_i,
   input  wire logic [23:0] addr_i,
   input  wire logic [1:0]  lat_i,
   output logic             ack_o,
   output logic [7:0]       rdata_o
);
   logic [1:0] wait_q;
   logic       ready_q;

   initial
   begin
      ack_o = 1'b0;
      rdata_o = 8'h00;
      wait_q = 2'h0;
      ready_q = 1'b0;
   end

   // data settles a cycle before ack; once released it flips so stale data is never seen
   always @(negedge clk_i)
   begin
      if (req_i && !ack_o)
      begin
         if (wait_q != lat_i)
            wait_q <= wait_q + 2'h1;
         else if (!ready_q)
         begin
            rdata_o <= addr_i[7:0] ^ 8'ha5;
            ready_q <= 1'b1;
         end
         else
            ack_o <= 1'b1;
      end
      else if (!req_i && ack_o)
      begin
         ack_o <= 1'b0;
         rdata_o <= ~rdata_o;
         wait_q <= 2'h0;
         ready_q <= 1'b0;
      end
   end
endmodule : pms_ext_mem

// *** sim/pms_mode_switch_tb_top.sv ***
`timescale 1ns/1ps
module pms_mode_switch_tb_top;
   import pms_pkg::*;
   logic sys_clk_i = 1'b0, arst_n_i = 1'b0, reg_wr_i = 1'b0, ins_take_i = 1'b0, branch_i = 1'b0;
   logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, rom_rdata_i = 8'h00, ext_rdata_i;
   logic [23:0] branch_target_i = 24'h00_8000, pc_o, rom_addr_o, ext_addr_o, first_ext;
   logic reg_busy_o, ins_valid_o, rom_en_o, ext_req_o, ext_ack_i, got_first = 1'b1;
   logic [1:0] mode_o, lat = 2'h0;
   pms_entry_s ins_o, e;
   int n_errors = 0, num_checks = 0, n_rom = 0, seed = 32'h67bad256;
   logic [23:0] a, t;

   always #4 sys_clk_i = ~sys_clk_i;

   pms_mode_switch dut (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .reg_wr_i(reg_wr_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_busy_o(reg_busy_o),
      .ins_valid_o(ins_valid_o), .ins_o(ins_o), .ins_take_i(ins_take_i), .branch_i(branch_i),
      .branch_target_i(branch_target_i), .pc_o(pc_o), .mode_o(mode_o), .rom_en_o(rom_en_o),
      .rom_addr_o(rom_addr_o), .rom_rdata_i(rom_rdata_i), .ext_req_o(ext_req_o),
      .ext_addr_o(ext_addr_o), .ext_ack_i(ext_ack_i), .ext_rdata_i(ext_rdata_i));
   pms_ext_mem mem (.clk_i(sys_clk_i), .req_i(ext_req_o), .addr_i(ext_addr_o), .lat_i(lat),
      .ack_o(ext_ack_i), .rdata_o(ext_rdata_i));

   // internal rom answers a cycle after the enable; rom bytes differ from external ones
   always @(negedge sys_clk_i)
   begin
      if (rom_en_o === 1'b1)
         rom_rdata_i = rom_addr_o[7:0] ^ 8'h3c;
      lat = 2'($random(seed));
   end

   // count rom reads and catch the first external address after a switch
   always @(posedge sys_clk_i)
   begin
      if (rom_en_o === 1'b1)
         n_rom++;
      if (ext_req_o === 1'b1 && !got_first)
      begin
         first_ext = ext_addr_o;
         got_first = 1'b1;
      end
   end

   function automatic logic [7:0] byte_at(input logic [23:0] ad, input logic ext);
      byte_at = ext ? (ad[7:0] ^ 8'ha5) : (ad[7:0] ^ 8'h3c);
   endfunction : byte_at

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : give_verdict

   task automatic chk_val(input string nm, input logic [23:0] exp, input logic [23:0] got);
      num_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk_val

   task automatic chk_ent(input logic [23:0] ad, input logic ext, input pms_entry_s got);
      chk_val("ins_o.data", 24'(byte_at(ad, ext)), 24'(got.data));
      chk_val("ins_o.ext", 24'(ext), 24'(got.ext));
      chk_val("ins_o.addr", ad, got.addr);
   endtask : chk_ent

   // pops the head once it is valid, bounded wait; an idle edge follows each pop
   task automatic take(output pms_entry_s ent);
      int k;
      for (k = 0; k < 200 && ins_valid_o !== 1'b1; k++)
         @(negedge sys_clk_i);
      ent = ins_o;
      if (k == 200)
      begin
         n_errors++;
         give_verdict();
      end
      else
      begin
         ins_take_i = 1'b1;
         @(negedge sys_clk_i);
         ins_take_i = 1'b0;
         @(negedge sys_clk_i);
      end
   endtask : take

   // one write, busy checked in the second of its two cycles and after it drops, mode checked after completion
   task automatic wr_mode(input logic [7:0] ad, input logic [7:0] d, input logic [1:0] m0);
      logic [1:0] m1;
      m1 = (ad == MODE_REG_ADR) ? d[1:0] : m0;
      got_first = 1'b0;
      reg_addr_i = ad;
      reg_wdata_i = d;
      reg_wr_i = 1'b1;
      @(negedge sys_clk_i);
      reg_wr_i = 1'b0;
      @(negedge sys_clk_i);
      chk_val("busy_c1", 24'(ad == MODE_REG_ADR), 24'(reg_busy_o));
      chk_val("mode_c1", 24'(m0), 24'(mode_o));
      @(negedge sys_clk_i);
      @(negedge sys_clk_i);
      chk_val("busy_c3", 24'h0, 24'(reg_busy_o));
      chk_val("mode_c3", 24'(m1), 24'(mode_o));
   endtask : wr_mode

   task automatic do_branch(input logic [23:0] tg);
      branch_target_i = tg;
      branch_i = 1'b1;
      @(negedge sys_clk_i);
      branch_i = 1'b0;
      chk_val("pc_branch", tg, pc_o);
      chk_val("valid_flush", 24'h0, 24'(ins_valid_o));
   endtask : do_branch

   initial
   begin
      repeat (3) @(negedge sys_clk_i);
      chk_val("pc_reset", 24'h00_8000, pc_o);
      chk_val("mode_reset", 24'(MODE_RESET), 24'(mode_o));
      arst_n_i = 1'b1;
      repeat (20) @(negedge sys_clk_i);
      chk_val("rom_reads_full", 24'h3, 24'(n_rom));
      $display("test queue_depth done");
      take(e);
      a = e.addr;
      chk_ent(24'h00_8000, 1'b0, e);
      wr_mode(8'h5d, 8'h02, MODE_SINGLE);
      wr_mode(MODE_REG_ADR, 8'hfe, MODE_SINGLE);
      chk_val("pc_switch", a + 24'h1, pc_o);
      for (int k = 1; k <= 6; k++)
      begin
         take(e);
         chk_ent(24'(a + k), (k > 3), e);
      end
      chk_val("first_ext_range", 24'h1, 24'(first_ext >= a + 1 && first_ext <= a + 4));
      $display("test mode_switch done");
      for (int m = 0; m < 8; m++)
      begin
         wr_mode(MODE_REG_ADR, (8'($random(seed)) & 8'hfc) | {6'h00, m[1:0]}, mode_o);
         t = 24'h00_8000 | (24'($random(seed)) & 24'h00_7ff0);
         if (m == 7)
            t = ROM_LIMIT_RST - 24'h1;
         do_branch(t);
         for (int k = 0; k < 4; k++)
         begin
            take(e);
            // past the rom range a fetch is external in every mode
            chk_ent(24'(t + k), (m[1:0] == 2'h2) || (t + k > ROM_LIMIT_RST), e);
         end
      end
      $display("test branch_modes done");
      give_verdict();
   end
endmodule : pms_mode_switch_tb_top
